// *** pafc_pkg.sv ***
// Purpose: shared constants and carrier types for the port link setup and
//          flow control block
// Assumes: 20 MHz clock
// Notes:   mode codes are ordered so a larger code is a better mode
package pafc_pkg;

  // resolved link modes, lowest first
  typedef enum logic [1:0] {
    PAFC_M10H  = 2'b00,
    PAFC_M10F  = 2'b01,
    PAFC_M100H = 2'b10,
    PAFC_M100F = 2'b11
  } pafc_mode_e;

  // ability bit positions in a four-bit ability vector
  localparam int PAFC_AB_10H  = 0;
  localparam int PAFC_AB_10F  = 1;
  localparam int PAFC_AB_100H = 2;
  localparam int PAFC_AB_100F = 3;
  localparam logic [3:0] PAFC_LOCAL_ABIL = 4'hf;

  // delay added to the collision domain budget at 100 half duplex, bit times
  localparam logic [7:0] PAFC_HDX100_DELAY_BT = 8'h32;

  // fill thresholds in words, resume below pause
  localparam int PAFC_FIFO_DEPTH  = 32;
  localparam int PAFC_PAUSE_LEVEL = 28;
  localparam int PAFC_RESUME_LEVEL = 16;

  // pause quanta sent in a pause frame, zero means resume
  localparam logic [15:0] PAFC_PAUSE_QUANTA = 16'hffff;

  // reset values
  localparam logic PAFC_RST_FORCE100 = 1'b0;
  localparam logic PAFC_RST_FIBER_FDX = 1'b1;

  // mode after resolution, carried to the rest of the port
  typedef struct packed {
    logic       up;
    logic       speed100;
    logic       full_duplex;
  } pafc_link_s;

  // request to the frame transmitter for a flow-control frame
  typedef struct packed {
    logic        valid;
    logic [15:0] quanta;
  } pafc_pause_req_s;

  // negotiation state
  typedef enum logic [1:0] {
    PAFC_DOWN   = 2'b00,
    PAFC_NEG    = 2'b01,
    PAFC_UP     = 2'b10
  } pafc_state_e;

endpackage

// *** pafc_fifo.sv ***
// Purpose: packet buffer fifo with valid/ready on both sides
// Assumes: single clock, depth a power of two
// Notes:   level output feeds the flow control thresholds
`timescale 1ns/1ps
module pafc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic                     clock,
  input  wire logic                     rstn,
  input  wire logic [WIDTH-1:0]         in_data,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("pafc_fifo: depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;
  logic             push, pop;

  // pointers carry an extra wrap bit so full and empty are exact
  always_comb begin
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    out_valid = wr_reg != rd_reg;
    out_data  = mem[rd_reg[AW-1:0]];
    level     = wr_reg - rd_reg;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // storage needs no reset
  always_ff @(posedge clock) begin
    if (push)
      mem[wr_reg[AW-1:0]] <= in_data;
  end
endmodule

// *** pafc_port.sv ***
// Purpose: per-port link setup and flow control for a fast ethernet port
// Assumes: all inputs synchronous to clock; partner abilities arrive as a
//          pulse with the received ability word
// Notes:   frame builders for pause frames and jam are outside this block
// How it works
// - negotiation picks best common mode: 100F, 100H, 10F, 10H
// - partner not negotiating: idle signal sets speed, run half duplex
// - negotiate on first link up and on every link return
// - management picks fixed 100 or negotiation; fixed mode takes duplex
// - 100 half duplex adds 50 bit times to path delay budget
// - full duplex nearly full buffer sends a pause frame
// - after pausing, resume frame sent when free space has grown
// - half duplex receiving while congested forces a collision
// - fiber ports at 100 default to full duplex after reset
`timescale 1ns/1ps
module pafc_port #(
  parameter int  WIDTH      = 8,
  parameter int  DEPTH      = pafc_pkg::PAFC_FIFO_DEPTH,
  parameter int  PAUSE_LVL  = pafc_pkg::PAFC_PAUSE_LEVEL,
  parameter int  RESUME_LVL = pafc_pkg::PAFC_RESUME_LEVEL,
  parameter bit  IS_FIBER   = 1'b0
) (
  input  wire logic                    clock,
  input  wire logic                    rstn,
  // link side
  input  wire logic                    link_ok,
  input  wire logic                    partner_abil_valid,
  input  wire logic [3:0]              partner_abil,
  input  wire logic                    idle_seen,
  input  wire logic                    idle_is_100,
  input  wire logic                    rx_active,
  // management
  input  wire logic                    force_100,
  input  wire logic                    fixed_fdx,
  // receive data into buffer, drained by the switch
  input  wire logic [WIDTH-1:0]        rx_data,
  input  wire logic                    rx_valid,
  output logic                         rx_ready,
  output logic [WIDTH-1:0]             sw_data,
  output logic                         sw_valid,
  input  wire logic                    sw_ready,
  // results
  output pafc_pkg::pafc_link_s         link,
  output logic [7:0]                   path_delay_budget,
  output pafc_pkg::pafc_pause_req_s    pause_req,
  output logic                         paused,
  output logic                         force_collision
);
  localparam int LW = $clog2(DEPTH) + 1;

  // bad settings are refused up front; otherwise the buffer could never
  // raise a pause, or never let one go
  initial begin
    if (!(RESUME_LVL < PAUSE_LVL))
      $error("pafc_port: resume level must lie below pause level");
    if (PAUSE_LVL > DEPTH)
      $error("pafc_port: pause level must fit in the buffer");
    if (RESUME_LVL < 0)
      $error("pafc_port: resume level must not be negative");
    if (WIDTH < 1)
      $error("pafc_port: data width must be at least one");
  end

  // best mode from one ability vector (caller passes the common set), 10H as fallback
  function automatic pafc_pkg::pafc_mode_e best_mode(input logic [3:0] a);
    if (a[pafc_pkg::PAFC_AB_100F])      best_mode = pafc_pkg::PAFC_M100F;
    else if (a[pafc_pkg::PAFC_AB_100H]) best_mode = pafc_pkg::PAFC_M100H;
    else if (a[pafc_pkg::PAFC_AB_10F])  best_mode = pafc_pkg::PAFC_M10F;
    else                                best_mode = pafc_pkg::PAFC_M10H;
  endfunction

  // buffer fill in words and the handshakes it is built from
  logic [LW-1:0] level;
  logic          fifo_in_ready, fifo_out_valid;
  logic [WIDTH-1:0] fifo_out_data;

  // the switch side can stall, so the buffer really fills
  // pause at the high mark leaves a few words of room for words in flight
  pafc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .in_data   (rx_data),
    .in_valid  (rx_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (sw_ready),
    .level     (level)
  );

  // ---- link resolution state
  pafc_pkg::pafc_state_e state_reg, state_next;
  pafc_pkg::pafc_link_s  link_reg, link_next;
  logic [7:0]            pdb_reg, pdb_next;
  logic                  fiber_fdx_reg, fiber_fdx_next;

  // any link loss returns to down so the next rise negotiates again
  always_comb begin
    state_next     = state_reg;
    link_next      = link_reg;
    fiber_fdx_next = fiber_fdx_reg;
    if (!link_ok) begin
      state_next = pafc_pkg::PAFC_DOWN;
      link_next  = '0;
    end else begin
      unique case (state_reg)
        pafc_pkg::PAFC_DOWN: begin
          if (IS_FIBER) begin
            // fiber has no negotiation; long runs need full duplex
            link_next  = '{up: 1'b1, speed100: 1'b1,
                          full_duplex: fiber_fdx_reg};
            state_next = pafc_pkg::PAFC_UP;
          end else if (force_100) begin
            link_next  = '{up: 1'b1, speed100: 1'b1,
                          full_duplex: fixed_fdx};
            state_next = pafc_pkg::PAFC_UP;
          end else begin
            state_next = pafc_pkg::PAFC_NEG;
          end
        end
        pafc_pkg::PAFC_NEG: begin
          if (partner_abil_valid) begin
            unique case (best_mode(partner_abil &
                                   pafc_pkg::PAFC_LOCAL_ABIL))
              pafc_pkg::PAFC_M100F: link_next = '{1'b1, 1'b1, 1'b1};
              pafc_pkg::PAFC_M100H: link_next = '{1'b1, 1'b1, 1'b0};
              pafc_pkg::PAFC_M10F:  link_next = '{1'b1, 1'b0, 1'b1};
              pafc_pkg::PAFC_M10H:  link_next = '{1'b1, 1'b0, 1'b0};
            endcase
            state_next = pafc_pkg::PAFC_UP;
          end else if (idle_seen) begin
            // idle pattern gives speed only; half duplex is the safe guess
            link_next  = '{up: 1'b1, speed100: idle_is_100,
                          full_duplex: 1'b0};
            state_next = pafc_pkg::PAFC_UP;
          end
        end
        // once up the mode is held; ability or management changes seen
        // now wait for the next link loss to take effect
        pafc_pkg::PAFC_UP: state_next = pafc_pkg::PAFC_UP;
        default: state_next = pafc_pkg::PAFC_DOWN;
      endcase
    end
    // only 100 half duplex joins a collision domain budget
    pdb_next = (link_next.up && link_next.speed100 &&
                !link_next.full_duplex) ?
               pafc_pkg::PAFC_HDX100_DELAY_BT : 8'h00;
  end

  // link registers; reset reports the link down until it is resolved
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg     <= pafc_pkg::PAFC_DOWN;
      link_reg      <= '0;
      pdb_reg       <= 8'h00;
      fiber_fdx_reg <= pafc_pkg::PAFC_RST_FIBER_FDX;
    end else begin
      state_reg     <= state_next;
      link_reg      <= link_next;
      pdb_reg       <= pdb_next;
      fiber_fdx_reg <= fiber_fdx_next;
    end
  end

  // ---- flow control state
  // full duplex stops the sender with pause frames; half duplex has no
  // such frame, so the port jams the wire instead while congested
  logic                      paused_reg, paused_next;
  pafc_pkg::pafc_pause_req_s req_reg, req_next;
  logic                      col_reg, col_next;
  logic                      fdx, hdx, hi, lo;

  // hysteresis between the two levels keeps frames from ping-ponging
  always_comb begin
    fdx = link_reg.up && link_reg.full_duplex;
    hdx = link_reg.up && !link_reg.full_duplex;
    hi  = level >= LW'(PAUSE_LVL);
    lo  = level <= LW'(RESUME_LVL);
    paused_next = paused_reg;
    req_next    = '0;
    // leaving full duplex drops the pause silently; the sender's own
    // pause timer runs out by itself
    if (!fdx) begin
      paused_next = 1'b0;
    end else if (!paused_reg && hi) begin
      paused_next = 1'b1;
      req_next    = '{valid: 1'b1,
                      quanta: pafc_pkg::PAFC_PAUSE_QUANTA};
    end else if (paused_reg && lo) begin
      paused_next = 1'b0;
      req_next    = '{valid: 1'b1, quanta: 16'h0000};
    end
    // jam only while the partner is actually sending
    col_next = hdx && rx_active && hi;
  end

  // flow registers; the request register clears so a pulse lasts one cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      paused_reg <= 1'b0;
      req_reg    <= '0;
      col_reg    <= 1'b0;
    end else begin
      paused_reg <= paused_next;
      req_reg    <= req_next;
      col_reg    <= col_next;
    end
  end

  // a partner that honours pause stops before the buffer overruns; if not,
  // rx_ready drops and the buffer refuses the word
  always_comb begin
    rx_ready          = fifo_in_ready;
    sw_data           = fifo_out_data;
    sw_valid          = fifo_out_valid;
    link              = link_reg;
    path_delay_budget = pdb_reg;
    pause_req         = req_reg;
    paused            = paused_reg;
    force_collision   = col_reg;
  end
endmodule

// *** pafc_port_asserts.sv ***
// Purpose: port level checks for link setup and flow control
// Assumes: fill count rebuilt from the two buffer handshakes
// Notes:   bound to every pafc_port instance
`timescale 1ns/1ps
module pafc_port_asserts #(
  parameter int DEPTH      = 32,
  parameter int PAUSE_LVL  = 28,
  parameter int RESUME_LVL = 16,
  parameter bit IS_FIBER   = 1'b0
) (
  input wire logic                      clock,
  input wire logic                      rstn,
  input wire logic                      link_ok,
  input wire logic                      rx_active,
  input wire logic                      force_100,
  input wire logic                      fixed_fdx,
  input wire logic                      rx_valid,
  input wire logic                      rx_ready,
  input wire logic                      sw_valid,
  input wire logic                      sw_ready,
  input wire pafc_pkg::pafc_link_s      link,
  input wire logic [7:0]                path_delay_budget,
  input wire pafc_pkg::pafc_pause_req_s pause_req,
  input wire logic                      paused,
  input wire logic                      force_collision
);
  logic [6:0] fill_reg;
  logic [6:0] fill_next;
  logic       hdx_full;
  // mirror of the buffer level; the level itself is not a port
  always_comb begin
    fill_next = fill_reg + 7'(rx_valid && rx_ready) - 7'(sw_valid && sw_ready);
    hdx_full = link.up && !link.full_duplex && fill_reg >= 7'(PAUSE_LVL);
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) fill_reg <= 7'h00;
    else fill_reg <= fill_next;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  pulse_width_a:
    assert property (pause_req.valid |=> !pause_req.valid)
      else $error("pause request held past one cycle");
  pause_sent_a:
    assert property (link_ok && link.up && link.full_duplex && $stable(link)
      && !paused && fill_reg >= 7'(PAUSE_LVL) |=> paused && pause_req.valid
      && pause_req.quanta == pafc_pkg::PAFC_PAUSE_QUANTA)
      else $error("no pause frame on nearly full buffer");
  resume_sent_a:
    assert property (link_ok && link.full_duplex && $stable(link) && paused
      && fill_reg <= 7'(RESUME_LVL) |=> !paused && pause_req.valid
      && pause_req.quanta == 16'h0000)
      else $error("no resume frame after buffer recovered");
  pause_holds_a:
    assert property (link_ok && $stable(link) && paused
      && fill_reg > 7'(RESUME_LVL) |=> paused)
      else $error("pause released above resume level");
  no_hdx_pause_a:
    assert property (link.up && !link.full_duplex && $stable(link)
      |-> !(pause_req.valid && pause_req.quanta != 16'h0000))
      else $error("pause frame on half duplex");
  jam_follows_a:
    assert property (1'b1 |=> force_collision == $past(hdx_full && rx_active))
      else $error("collision force wrong");
  delay_budget_a:
    assert property (path_delay_budget == ((link == 3'b110) ?
      pafc_pkg::PAFC_HDX100_DELAY_BT : 8'h00))
      else $error("path delay budget wrong");
  link_drop_a:
    assert property (!link_ok |=> !link.up) else $error("link kept after loss");
  fixed_mode_a:
    assert property (!IS_FIBER && force_100 && $rose(link_ok)
      |=> link.up && link.speed100 && link.full_duplex == fixed_fdx)
      else $error("fixed mode not applied");
  fiber_fdx_a:
    assert property (IS_FIBER && $rose(link_ok) |=> link == 3'b111)
      else $error("fiber port not up at 100 full duplex");
  cover property ($rose(paused));
  cover property (pause_req.valid && pause_req.quanta == 16'h0000);
  cover property ($rose(force_collision));
  cover property (link == 3'b110);
endmodule
bind pafc_port pafc_port_asserts #(.DEPTH(DEPTH), .PAUSE_LVL(PAUSE_LVL),
  .RESUME_LVL(RESUME_LVL), .IS_FIBER(IS_FIBER))
  pafc_port_asserts_inst (.clock(clock),
  .rstn(rstn), .link_ok(link_ok), .rx_active(rx_active),
  .force_100(force_100), .fixed_fdx(fixed_fdx), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .sw_valid(sw_valid), .sw_ready(sw_ready),
  .link(link), .path_delay_budget(path_delay_budget),
  .pause_req(pause_req), .paused(paused),
  .force_collision(force_collision));

// *** pafc_peer.sv ***
// Purpose: sending station model feeding the port buffer
// Assumes: word held until the buffer takes it
// Notes:   slow mode leaves a gap between words
`timescale 1ns/1ps
module pafc_peer (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       send,
  input wire logic       slow,
  input wire logic       paused,
  input wire logic       rx_ready,
  output logic [7:0]     rx_data,
  output logic           rx_valid
);
  logic [7:0] seq;
  logic       took;
  logic       gap;
  logic       go;
  // a paused station starts no new word
  assign go = send && !paused && !(slow && !gap);
  always @(posedge clock) took <= rx_valid && rx_ready;
  // idle data toggles so a stale word never looks valid
  always @(negedge clock or negedge rstn) begin
    if (!rstn) begin
      seq <= 8'h00;
      gap <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'hff;
    end else if (!rx_valid || took) begin
      gap <= slow && !gap;
      rx_valid <= go;
      rx_data <= go ? seq : ~rx_data;
      if (go) seq <= seq + 8'h01;
    end
  end
endmodule

// *** tb_top.sv ***
// Purpose: self-checking bench for the port block
// Assumes: inputs change on the falling edge
// Notes:   fiber variant shares the stimulus; only its mode is compared
`timescale 1ns/1ps
module tb_top;
  logic clock = 0, rstn = 0, link_ok = 0, partner_abil_valid = 0;
  logic idle_seen = 0, idle_is_100 = 0, rx_active = 0, force_100 = 0;
  logic fixed_fdx = 0, rx_valid, rx_ready, sw_valid, sw_ready = 1;
  logic paused, force_collision, send = 0, slow = 0;
  logic [3:0] partner_abil = 0;
  logic [7:0] rx_data, sw_data, path_delay_budget;
  pafc_pkg::pafc_link_s link, link_fb;
  pafc_pkg::pafc_pause_req_s pause_req;
  int n_errors = 0, n_checks = 0, n_pz = 0, n_rs = 0, cyc = 0, i;
  logic [3:0] abl [5] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'h6};
  pafc_port pafc_port_inst (.clock(clock), .rstn(rstn), .link_ok(link_ok),
    .partner_abil_valid(partner_abil_valid), .partner_abil(partner_abil),
    .idle_seen(idle_seen), .idle_is_100(idle_is_100),
    .rx_active(rx_active), .force_100(force_100), .fixed_fdx(fixed_fdx),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .sw_data(sw_data), .sw_valid(sw_valid), .sw_ready(sw_ready),
    .link(link), .path_delay_budget(path_delay_budget),
    .pause_req(pause_req), .paused(paused),
    .force_collision(force_collision));
  // fiber variant sees the same link and feed; only its mode is compared
  pafc_port #(.IS_FIBER(1'b1)) pafc_port_fiber_inst (.clock(clock),
    .rstn(rstn), .link_ok(link_ok), .partner_abil_valid(partner_abil_valid),
    .partner_abil(partner_abil), .idle_seen(idle_seen),
    .idle_is_100(idle_is_100), .rx_active(rx_active),
    .force_100(force_100), .fixed_fdx(fixed_fdx), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(), .sw_data(), .sw_valid(),
    .sw_ready(sw_ready), .link(link_fb), .path_delay_budget(),
    .pause_req(), .paused(), .force_collision());
  pafc_peer pafc_peer_inst (.clock(clock), .rstn(rstn), .send(send),
    .slow(slow), .paused(paused), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid));
  always #25 clock = ~clock;
  // count flow frames mid-cycle, where each pulse stands; cut a hang short
  always @(negedge clock) begin
    cyc++;
    if (pause_req.valid === 1'b1) begin
      if (pause_req.quanta === 16'hffff) n_pz++;
      else if (pause_req.quanta === 16'h0000) n_rs++;
    end
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  function automatic logic [2:0] best(input logic [3:0] a);
    return a[3] ? 3'b111 : a[2] ? 3'b110 : a[1] ? 3'b101 : 3'b100;
  endfunction
  // drop the link, raise it, then offer abilities or idle
  task automatic connect(input int kind, input logic [3:0] v);
    @(negedge clock) link_ok = 0;
    @(negedge clock) link_ok = 1;
    @(negedge clock);
    partner_abil = v;
    idle_is_100 = v[0];
    partner_abil_valid = (kind == 0);
    idle_seen = (kind == 1);
    @(negedge clock) partner_abil_valid = 0;
    idle_seen = 0;
    for (i = 0; i < 8 && link.up !== 1'b1; i++) @(negedge clock);
  endtask
  // read side: every word must follow the last by one
  task automatic drain(input int exp_n);
    int n;
    logic [7:0] prev;
    n = 0;
    @(negedge clock) sw_ready = 1;
    while (sw_valid === 1'b1 && n < 40) begin
      if (n > 0) chk(sw_data, 8'(prev + 8'h01));
      prev = sw_data;
      n++;
      @(negedge clock);
    end
    chk(n, exp_n);
  endtask
  initial begin
    repeat (3) @(negedge clock);
    rstn = 1;
    chk({link, path_delay_budget, pause_req, paused, force_collision,
      rx_ready, sw_valid}, 32'h0000_0002);
    foreach (abl[k]) begin
      connect(0, abl[k]);
      chk(link, best(abl[k]));
      chk(path_delay_budget, best(abl[k]) == 3'b110 ? 8'h32 : 8'h00);
    end
    for (int s = 0; s < 2; s++) begin
      connect(1, 4'(s));
      chk(link, {1'b1, s[0], 1'b0});
    end
    force_100 = 1;
    for (int d = 0; d < 2; d++) begin
      fixed_fdx = d[0];
      connect(2, 4'h0);
      chk(link, {2'b11, d[0]});
      chk(link_fb, 3'b111);
    end
    force_100 = 0;
    connect(0, 4'hf);
    sw_ready = 0;
    send = 1;
    slow = 1;
    for (i = 0; i < 200 && paused !== 1'b1; i++) @(negedge clock);
    @(negedge clock);
    chk(paused, 1);
    chk(n_pz, 1);
    sw_ready = 1;
    slow = 0;
    for (i = 0; i < 200 && paused !== 1'b0; i++) @(negedge clock);
    @(negedge clock);
    chk(n_rs, 1);
    repeat (40) @(negedge clock);
    chk(n_pz, 1);
    send = 0;
    repeat (40) @(negedge clock);
    connect(0, 4'h1);
    sw_ready = 0;
    rx_active = 1;
    send = 1;
    for (i = 0; i < 200 && rx_ready !== 1'b0; i++) @(negedge clock);
    @(negedge clock) chk(force_collision, 1);
    chk(n_pz, 1);
    send = 0;
    rx_active = 0;
    drain(33);
    chk(force_collision, 0);
    test_done();
  end
endmodule
